// file: inc/uevs_pkg.sv
// constants and types for the usb event vector and suspend block
package uevs_pkg;
	localparam logic [7:0] UEVS_OFS_VECTOR  = 8'hF8;
	localparam logic [7:0] UEVS_OFS_STATUS  = 8'hF9;
	localparam logic [7:0] UEVS_OFS_MASK    = 8'hFA;
	localparam logic [7:0] UEVS_OFS_CONTROL = 8'hFC;
	localparam logic [7:0] UEVS_OFS_CTRINFO = 8'hFD;
	localparam int UEVS_ST_MISSED = 0;
	localparam int UEVS_ST_SOF    = 1;
	localparam int UEVS_ST_RESET  = 2;
	localparam int UEVS_ST_SUSPEND_REQUEST   = 3;
	localparam int UEVS_ST_END_OF_SUSPEND  = 4;
	localparam int UEVS_ST_ERR    = 5;
	localparam int UEVS_ST_DMA_OVER_UNDERRUN   = 6;
	localparam int UEVS_CTL_LP    = 1;
	localparam int UEVS_CTL_MODE  = 4;
	localparam int UEVS_CTL_TIM   = 6;
	localparam logic [6:0] UEVS_STATUS_RST = 7'h00;
	localparam logic [6:0] UEVS_MASK_RST   = 7'h00;
	localparam logic [3:0] UEVS_EP_ALL_ONES = 4'hF;
	localparam int UEVS_CLK_HZ     = 50000000;
	localparam int UEVS_IDLE_US    = 3000;
	localparam int UEVS_FRAME_US   = 1000;
	localparam int UEVS_FRAME_MARGIN_US = 10;
	localparam int UEVS_IDLE_CYCLES  = UEVS_IDLE_US * (UEVS_CLK_HZ / 1000000);
	localparam int UEVS_FRAME_CYCLES =
		(UEVS_FRAME_US + UEVS_FRAME_MARGIN_US) * (UEVS_CLK_HZ / 1000000);
	localparam int UEVS_CNT_W = 18;

	typedef struct packed {
		logic dma_over_underrun;
		logic dma_over_underrun_rx;
		logic no_answer_timeout;
		logic crc_error;
		logic stuffing_error;
		logic framing_violation;
		logic buffer_overrun;
		logic bus_reset;
		logic sof_rx;
		logic traffic;
	} uevs_evt_t;

	typedef struct packed {
		logic [7:0] addr;
		logic       wr;
		logic [7:0] wdata;
	} uevs_rbus_t;
endpackage : uevs_pkg

// file: rtl/uevs_top.sv
// usb interrupt vectoring, event status, mask and suspend wake-up
`timescale 1ns/10ps
module uevs_top #(
	parameter int IDLE_CYCLES  = uevs_pkg::UEVS_IDLE_CYCLES,
	parameter int FRAME_CYCLES = uevs_pkg::UEVS_FRAME_CYCLES,
	parameter int NUM_EP       = 16
) (
	input  wire logic               mclk,
	input  wire logic               srst,
	input  wire uevs_pkg::uevs_rbus_t rbus,
	output logic [7:0]              rdata,
	input  wire uevs_pkg::uevs_evt_t  evt,
	input  wire logic [NUM_EP-1:0]  ctr_pend,
	input  wire logic [NUM_EP-1:0]  ctr_iso,
	input  wire logic               usb_activity_pin,
	input  wire logic               stop_clock_enable,
	output logic                    irq,
	output logic                    wake_line_15,
	output logic                    low_power_suspend,
	output logic                    pullup_supply_on,
	output logic                    withhold_ack,
	output logic                    force_stuff_error,
	output logic                    addr_ep_reset
);
	import uevs_pkg::*;

	typedef struct packed {
		logic [6:0]            status;
		logic [6:0]            mask;
		logic [1:0]            table_base;
		logic [6:0]            single_vec;
		logic [4:0]            hw_vec;
		logic                  mode_single;
		logic                  timed_suspend;
		logic                  lp;
		logic                  idle_armed;
		logic [UEVS_CNT_W-1:0] idle_cnt;
		logic [UEVS_CNT_W-1:0] frame_cnt;
		logic                  frame_seen;
		logic                  act_meta;
		logic                  act_sync;
		logic [7:0]            rdata;
		logic                  irq;
		logic                  wake;
		logic                  withhold;
		logic                  stuff;
		logic                  addr_rst;
	} uevs_state_t;

	uevs_state_t st_reg;
	uevs_state_t st_next;

	localparam logic [UEVS_CNT_W-1:0] IDLE_LIMIT  = UEVS_CNT_W'(IDLE_CYCLES - 1);
	localparam logic [UEVS_CNT_W-1:0] FRAME_LIMIT = UEVS_CNT_W'(FRAME_CYCLES - 1);
	localparam logic [UEVS_CNT_W-1:0] CNT_ONE     = UEVS_CNT_W'(1);
	localparam logic [UEVS_CNT_W-1:0] CNT_ZERO    = '0;

	// lowest endpoint number wins, endpoint 0 first
	function automatic logic [3:0] lowest_ep(input logic [NUM_EP-1:0] v);
		logic [3:0] r;
		r = 4'h0;
		for (int i = NUM_EP - 1; i >= 0; i--) begin
			if (v[i]) begin
				r = 4'(i);
			end
		end
		return r;
	endfunction : lowest_ep

	logic [6:0]        ev_set;
	logic [6:0]        keep_mask;
	logic [6:0]        active;
	logic [NUM_EP-1:0] iso_pend;
	logic [NUM_EP-1:0] std_pend;
	logic              notify_pend;
	logic              wr_vec;
	logic              wr_stat;
	logic              wr_mask;
	logic              wr_ctl;
	logic              any_error;
	logic              wake_evt;
	logic [7:0]        vec_view;
	logic [7:0]        rd_mux;

	always_comb begin
		st_next = st_reg;

		wr_vec  = rbus.wr && (rbus.addr == UEVS_OFS_VECTOR);
		wr_stat = rbus.wr && (rbus.addr == UEVS_OFS_STATUS);
		wr_mask = rbus.wr && (rbus.addr == UEVS_OFS_MASK);
		wr_ctl  = rbus.wr && (rbus.addr == UEVS_OFS_CONTROL);

		// activity in suspend; synced copy only, clock is assumed alive
		wake_evt = st_reg.lp && st_reg.act_sync;
		st_next.act_meta = usb_activity_pin;
		st_next.act_sync = st_reg.act_meta;

		any_error = evt.no_answer_timeout | evt.crc_error | evt.stuffing_error
			| evt.framing_violation | evt.buffer_overrun;

		ev_set = 7'h00;
		ev_set[UEVS_ST_DMA_OVER_UNDERRUN]  = evt.dma_over_underrun;
		ev_set[UEVS_ST_ERR]   = any_error;
		ev_set[UEVS_ST_END_OF_SUSPEND] = wake_evt;
		ev_set[UEVS_ST_RESET] = evt.bus_reset;
		ev_set[UEVS_ST_SOF]   = evt.sof_rx;

		// idle-bus detector for suspend request
		if (evt.bus_reset) begin
			st_next.idle_armed = 1'b1;
			st_next.idle_cnt   = CNT_ZERO;
		end else if (st_reg.lp) begin
			st_next.idle_cnt = CNT_ZERO;
		end else if (evt.traffic) begin
			st_next.idle_cnt = CNT_ZERO;
		end else if (st_reg.idle_armed) begin
			if (st_reg.idle_cnt == IDLE_LIMIT) begin
				ev_set[UEVS_ST_SUSPEND_REQUEST] = 1'b1;
				st_next.idle_cnt     = CNT_ZERO;
			end else begin
				st_next.idle_cnt = st_reg.idle_cnt + CNT_ONE;
			end
		end

		// missed frame start once frames have begun
		if (evt.sof_rx || evt.bus_reset || st_reg.lp) begin
			st_next.frame_cnt  = CNT_ZERO;
			st_next.frame_seen = evt.sof_rx;
		end else if (st_reg.frame_seen) begin
			if (st_reg.frame_cnt == FRAME_LIMIT) begin
				ev_set[UEVS_ST_MISSED] = 1'b1;
				st_next.frame_cnt      = CNT_ZERO;
			end else begin
				st_next.frame_cnt = st_reg.frame_cnt + CNT_ONE;
			end
		end

		// a zero written clears, a one keeps; new events always land
		keep_mask = wr_stat ? rbus.wdata[6:0] : 7'h7F;
		st_next.status = (st_reg.status & keep_mask) | ev_set;

		if (wr_mask) begin
			st_next.mask = rbus.wdata[6:0];
		end

		if (wr_vec) begin
			st_next.table_base = rbus.wdata[7:6];
			st_next.single_vec = rbus.wdata[7:1];
		end

		if (wr_ctl) begin
			st_next.timed_suspend = rbus.wdata[UEVS_CTL_TIM];
			st_next.mode_single   = rbus.wdata[UEVS_CTL_MODE];
			st_next.lp            = rbus.wdata[UEVS_CTL_LP];
		end
		if (wake_evt) begin
			st_next.lp = 1'b0;
		end
		// idle check resumes only when the resume has finished
		if (st_reg.lp && !st_next.lp) begin
			st_next.idle_armed = 1'b1;
		end

		active      = st_reg.status & st_reg.mask;
		iso_pend    = ctr_pend & ctr_iso;
		std_pend    = ctr_pend & ~ctr_iso;
		notify_pend = |active[UEVS_ST_ERR:UEVS_ST_MISSED];

		// ranking: dma first, then iso, then other transfers, then notify
		if (active[UEVS_ST_DMA_OVER_UNDERRUN]) begin
			st_next.hw_vec = {1'b0, UEVS_EP_ALL_ONES};
		end else if (|iso_pend) begin
			st_next.hw_vec = {1'b1, lowest_ep(iso_pend)};
		end else if (|std_pend) begin
			st_next.hw_vec = {1'b1, lowest_ep(std_pend)};
		end else if (notify_pend) begin
			st_next.hw_vec = {1'b0, UEVS_EP_ALL_ONES};
		end else begin
			st_next.hw_vec = st_reg.hw_vec;
		end

		// one request for any mix of unmasked flags and pending transfers
		st_next.irq = (|active) | (|ctr_pend);

		// wake line pulses from end-of-suspend when clock stop is enabled
		st_next.wake = wake_evt && stop_clock_enable;

		st_next.withhold = evt.dma_over_underrun && evt.dma_over_underrun_rx;
		st_next.stuff    = evt.dma_over_underrun && !evt.dma_over_underrun_rx;
		st_next.addr_rst = evt.bus_reset;

		if (st_reg.mode_single) begin
			vec_view = {st_reg.single_vec, 1'b0};
		end else begin
			vec_view = {st_reg.table_base, st_reg.hw_vec, 1'b0};
		end

		case (rbus.addr)
			UEVS_OFS_VECTOR:  rd_mux = vec_view;
			UEVS_OFS_STATUS:  rd_mux = {1'b0, st_reg.status};
			UEVS_OFS_MASK:    rd_mux = {1'b0, st_reg.mask};
			UEVS_OFS_CONTROL: rd_mux = {1'b0, st_reg.timed_suspend, 1'b0,
				st_reg.mode_single, 2'b00, st_reg.lp, 1'b0};
			UEVS_OFS_CTRINFO: rd_mux = {2'b00, st_reg.hw_vec, 1'b0};
			default:          rd_mux = 8'h00;
		endcase
		st_next.rdata = rd_mux;
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			st_reg             <= '0;
			st_reg.status      <= UEVS_STATUS_RST;
			st_reg.mask        <= UEVS_MASK_RST;
			st_reg.mode_single <= 1'b1;
			st_reg.idle_armed  <= 1'b1;
			st_reg.hw_vec      <= {1'b0, UEVS_EP_ALL_ONES};
		end else begin
			st_reg <= st_next;
		end
	end

	// the pull-up supply is the one load kept alive in suspend
	always_ff @(posedge mclk) begin
		if (srst) begin
			pullup_supply_on <= 1'b0;
		end else begin
			pullup_supply_on <= 1'b1;
		end
	end

	assign rdata             = st_reg.rdata;
	assign irq               = st_reg.irq;
	assign wake_line_15      = st_reg.wake;
	assign low_power_suspend = st_reg.lp;
	assign withhold_ack      = st_reg.withhold;
	assign force_stuff_error = st_reg.stuff;
	assign addr_ep_reset     = st_reg.addr_rst;
endmodule : uevs_top

// file: tb/uevs_assertions.sv
// port assertions for the usb event vector and suspend block
`timescale 1ns/10ps
module uevs_assertions #(parameter int NUM_EP = 16) (
	input wire logic                 mclk,
	input wire logic                 srst,
	input wire uevs_pkg::uevs_rbus_t rbus,
	input wire logic [7:0]           rdata,
	input wire uevs_pkg::uevs_evt_t  evt,
	input wire logic [NUM_EP-1:0]    ctr_pend,
	input wire logic                 usb_activity_pin,
	input wire logic                 irq,
	input wire logic                 wake_line_15,
	input wire logic                 low_power_suspend,
	input wire logic                 pullup_supply_on,
	input wire logic                 withhold_ack,
	input wire logic                 force_stuff_error,
	input wire logic                 addr_ep_reset
);
	import uevs_pkg::*;
	default clocking @(posedge mclk); endclocking
	default disable iff (srst);
	// two samples of the pin so the synchroniser has seen it
	sequence s_wake_req;
		low_power_suspend && usb_activity_pin ##1 usb_activity_pin;
	endsequence
	chk_dma_over_underrun_rx_nak: assert property (evt.dma_over_underrun && evt.dma_over_underrun_rx |=> withhold_ack)
		else $error("receive overrun without withheld ack");
	chk_dma_over_underrun_tx_stuff: assert property (evt.dma_over_underrun && !evt.dma_over_underrun_rx |=> force_stuff_error)
		else $error("transmit underrun without stuffing error");
	chk_bus_reset_regs: assert property (evt.bus_reset |=> addr_ep_reset)
		else $error("bus reset did not reset address registers");
	chk_status_top_bit: assert property (rbus.addr == UEVS_OFS_STATUS |=> !rdata[7])
		else $error("status bit 7 read as one");
	chk_ctr_irq: assert property (ctr_pend != '0 |=> irq)
		else $error("pending transfer raised no request");
	chk_wake_resume: assert property (s_wake_req |-> ##[1:4] !low_power_suspend)
		else $error("bus activity did not end suspend");
	chk_wake_line_cause: assert property (wake_line_15 |-> $past(low_power_suspend)
		&& !low_power_suspend)
		else $error("wake pulse without end of suspend");
	chk_pullup_kept: assert property (!$past(srst) |-> pullup_supply_on)
		else $error("pull-up supply off in suspend");
endmodule : uevs_assertions

// file: tb/uevs_core_model.sv
// core side model: counts wake pulses that release the halted core
`timescale 1ns/10ps
module uevs_core_model (
	input  wire logic  mclk,
	input  wire logic  srst,
	input  wire logic  wake_line_15,
	output logic [7:0] wakes
);
	always_ff @(posedge mclk) begin
		if (srst) wakes <= 8'h00;
		else if (wake_line_15) wakes <= wakes + 8'h01;
	end
endmodule : uevs_core_model

// file: tb/test_uevs.sv
// self-checking bench for the usb event vector and suspend block
`timescale 1ns/10ps
module test_uevs;
	import uevs_pkg::*;
	localparam int NUM_EP = 16;
	logic              mclk = 0, srst = 1, usb_activity_pin = 0, stop_clock_enable = 0;
	uevs_rbus_t        rbus = '0;
	uevs_evt_t         evt = uevs_evt_t'(10'h001);
	logic [NUM_EP-1:0] ctr_pend = '0, ctr_iso = '0;
	logic [7:0]        rdata, wakes;
	logic              irq, wake_line_15, low_power_suspend, pullup_supply_on;
	logic              withhold_ack, force_stuff_error, addr_ep_reset;
	int                failures = 0, n_tests = 0;
	// event pattern beside expected status; traffic held high so no idle flag
	logic [17:0]       rows [8] = '{{10'h301, 8'h40}, {10'h081, 8'h20}, {10'h041, 8'h20},
		{10'h021, 8'h20}, {10'h011, 8'h20}, {10'h009, 8'h20}, {10'h005, 8'h04},
		{10'h003, 8'h02}};
	uevs_top #(.IDLE_CYCLES(40), .FRAME_CYCLES(30), .NUM_EP(NUM_EP)) uevs_top_i (.*);
	uevs_core_model uevs_core_model_i (.*);
	initial forever #10 mclk = ~mclk;
	task automatic chk(string name, logic [7:0] exp, logic [7:0] seen);
		n_tests++;
		if (seen !== exp) begin
			failures++;
			$display("unexpected %s: expected %h seen %h", name, exp, seen);
		end
	endtask : chk
	task automatic wr(logic [7:0] a, logic [7:0] d);
		@(posedge mclk) rbus <= '{a, 1'b1, d};
		@(posedge mclk) rbus.wr <= 1'b0;
	endtask : wr
	task automatic rd(logic [7:0] a, string name, logic [7:0] exp);
		@(posedge mclk) rbus.addr <= a;
		@(posedge mclk) #1 chk(name, exp, rdata);
	endtask : rd
	task automatic pulse(uevs_evt_t e);
		@(posedge mclk) evt <= e;
		@(posedge mclk) evt <= '{traffic: e.traffic, default: 1'b0};
	endtask : pulse
	task automatic summarize;
		$display("checks %0d, mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : summarize
	initial begin
		repeat (20000) @(posedge mclk);
		failures++;
		summarize();
	end
	initial begin
		repeat (4) @(posedge mclk);
		srst <= 1'b0;
		foreach (rows[i]) begin
			pulse(rows[i][17:8]);
			rd(UEVS_OFS_STATUS, "status", rows[i][7:0]);
			wr(UEVS_OFS_STATUS, 8'h00);
		end
		pulse(10'h003);
		pulse(10'h005);
		#1 chk("addr reset", 8'h01, {7'h0, addr_ep_reset});
		chk("pullup", 8'h01, {7'h0, pullup_supply_on});
		wr(UEVS_OFS_STATUS, 8'hFB);
		rd(UEVS_OFS_STATUS, "status", 8'h02);
		wr(UEVS_OFS_MASK, 8'h02);
		@(posedge mclk) #1 chk("irq", 8'h01, {7'h0, irq});
		wr(UEVS_OFS_MASK, 8'h00);
		@(posedge mclk) #1 chk("irq", 8'h00, {7'h0, irq});
		wr(UEVS_OFS_CONTROL, 8'h10);
		wr(UEVS_OFS_VECTOR, 8'h57);
		rd(UEVS_OFS_VECTOR, "vector", 8'h56);
		wr(UEVS_OFS_CONTROL, 8'h00);
		wr(UEVS_OFS_VECTOR, 8'h80);
		@(posedge mclk) {ctr_pend, ctr_iso} <= {16'h0030, 16'h0020};
		rd(UEVS_OFS_VECTOR, "vector", 8'hAA);
		@(posedge mclk) ctr_iso <= '0;
		rd(UEVS_OFS_VECTOR, "vector", 8'hA8);
		@(posedge mclk) ctr_pend <= 16'h0001;
		wr(UEVS_OFS_MASK, 8'h42);
		pulse(10'h201);
		#1 chk("stuff", 8'h01, {7'h0, force_stuff_error});
		rd(UEVS_OFS_VECTOR, "vector", 8'h9E);
		@(posedge mclk) ctr_pend <= '0;
		rd(UEVS_OFS_VECTOR, "vector", 8'h9E);
		wr(UEVS_OFS_STATUS, 8'h00);
		wr(UEVS_OFS_MASK, 8'h00);
		@(posedge mclk) {evt, stop_clock_enable} <= {10'h000, 1'b1};
		wr(UEVS_OFS_CONTROL, 8'h42);
		#1 chk("suspend", 8'h01, {7'h0, low_power_suspend});
		repeat (60) @(posedge mclk);
		rd(UEVS_OFS_STATUS, "status", 8'h00);
		@(posedge mclk) usb_activity_pin <= 1'b1;
		repeat (5) @(posedge mclk);
		usb_activity_pin <= 1'b0;
		rd(UEVS_OFS_STATUS, "status", 8'h10);
		chk("suspend", 8'h00, {7'h0, low_power_suspend});
		chk("wakes", 8'h01, wakes);
		repeat (45) @(posedge mclk);
		rd(UEVS_OFS_STATUS, "status", 8'h18);
		@(posedge mclk) srst <= 1'b1;
		repeat (4) @(posedge mclk);
		srst <= 1'b0;
		rd(UEVS_OFS_MASK, "mask", 8'h00);
		rd(UEVS_OFS_STATUS, "status", 8'h00);
		rd(8'hF0, "unmapped", 8'h00);
		// one frame start, then no further frame start: missed frame start after the frame window
		pulse(10'h003);
		repeat (35) @(posedge mclk);
		rd(UEVS_OFS_STATUS, "status", 8'h03);
		summarize();
	end
endmodule : test_uevs
bind uevs_top uevs_assertions #(.NUM_EP(NUM_EP)) uevs_assertions_i (.*);
